// ---- embedded_ram_block.v ----
// Embedded RAM block: 9-bit lane storage in four banks, two user ports,
// shape and mode set over a classic Wishbone slave.
// Assumes user ports come from fabric logic on clk_sys (no synchronisers).
`timescale 1ns/1ps
`default_nettype none
`include "embedded_ram_block_defs.vh"

// What this block does
// - Holds 8192 data bits, 9216 with parity.
// - Each port has independent read and write strobes.
// - Packed mode gives two half-size single-port memories.
// - Byte enables mask bytes during writes.
// - Two clock enables per port gate operation.
// - Single-port: one shared address per access.
// - Read during write shows new or old data.
// - Write without read keeps last read output.
// - Nine selectable depth-by-width shapes.
// - Dual-port allows read/write, two reads, two writes.
// - Contents can be preloaded, in RAM or ROM use.
module embedded_ram_block (
  input  wire        clk_sys,
  input  wire        rstn,
  input  wire [7:0]  wb_adr_i,
  input  wire [31:0] wb_dat_i,
  input  wire [3:0]  wb_sel_i,
  input  wire        wb_we_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire [12:0] addrA,
  input  wire [35:0] dataInA,
  input  wire [3:0]  byteEnA,
  input  wire        readEnA,
  input  wire        writeEnA,
  input  wire        clkEnInA,
  input  wire        clkEnOutA,
  output reg  [35:0] dataOutA,
  input  wire [12:0] addrB,
  input  wire [35:0] dataInB,
  input  wire [3:0]  byteEnB,
  input  wire        readEnB,
  input  wire        writeEnB,
  input  wire        clkEnInB,
  input  wire        clkEnOutB,
  output reg  [35:0] dataOutB
);

  ////////////////////////////////////////////////////////////////////////
  // Address and data shaping helpers

  // Storage map, shared by both ports:
  //   lane = 9 bits, 1024 lanes, lane l sits in bank l[1:0], row l[9:2]
  //   x1   lane addr[12:3], bit addr[2:0]
  //   x2   lane addr[11:2], bit pair addr[1:0]
  //   x4   lane addr[10:1], nibble addr[0]
  //   x8   lane addr[9:0], lane bit 8 kept on write
  //   x9   lane addr[9:0], all nine bits
  //   x16  lanes 2a and 2a+1, low lane holds the low byte
  //   x18  as x16 with the ninth bits carried
  //   x32  lanes 4a..4a+3, one byte per bank
  //   x36  lanes 4a..4a+3, whole word across banks
  // Packed use forces lane bit 9 to the port number, so each port sees
  // its own half and the top address bit of each shape is dropped.
  // Changing shape never clears storage: old lanes are read in the new
  // shape, which lets software repack data without a copy loop.

  // Lane index of an access; packed mode pins the top row bit to the port
  // Wide shapes return the lowest lane of the word; banks add their own
  function [9:0] laneOf;
    input [3:0]  wid;
    input [12:0] a;
    input        pk;
    input        portId;
    reg   [9:0]  l;
    begin
      case (wid)
        `WID_X1:            l = a[12:3];
        `WID_X2:            l = a[11:2];
        `WID_X4:            l = a[10:1];
        `WID_X8, `WID_X9:   l = a[9:0];
        `WID_X16, `WID_X18: l = {a[8:0], 1'b0};
        default:            l = {a[7:0], 2'b00};
      endcase
      if (pk) begin
        l[9] = portId; // Each half keeps 128 rows, 4.5K bits
      end
      laneOf = l;
    end
  endfunction

  // Log2 of lanes spanned by one word
  // Unknown width codes fall to one lane, so they never write wide
  function [1:0] spanOf;
    input [3:0] wid;
    begin
      case (wid)
        `WID_X16, `WID_X18: spanOf = 2'h1;
        `WID_X32, `WID_X36: spanOf = 2'h2;
        default:            spanOf = 2'h0;
      endcase
    end
  endfunction

  // New lane content after writing word lane k into old lane
  // Narrow shapes merge into the old lane, so neighbours survive
  function [8:0] wrLane;
    input [3:0]  wid;
    input [8:0]  old;
    input [35:0] din;
    input [1:0]  k;
    input [2:0]  a;
    reg   [8:0]  r;
    begin
      r = old;
      case (wid)
        `WID_X1: r[a] = din[0];
        `WID_X2: r[{a[1:0], 1'b0} +: 2] = din[1:0];
        `WID_X4: r[{a[0], 2'b00} +: 4] = din[3:0];
        `WID_X8, `WID_X16, `WID_X32: r[7:0] = din[{k, 3'b000} +: 8];
        `WID_X9, `WID_X18, `WID_X36: r = din[{4'h0, k} * 6'h09 +: 9];
        default: r = old;
      endcase
      wrLane = r;
    end
  endfunction

  // Word assembled from the four bank lanes (lane b at bits 9b+8..9b)
  // Bits above the word width read as zero; byte shapes drop bit 8
  function [35:0] rdWord;
    input [3:0]  wid;
    input [35:0] v;
    input [1:0]  lsel;
    input [2:0]  a;
    reg   [8:0]  one;
    reg   [8:0]  lo;
    reg   [8:0]  hi;
    reg   [35:0] r;
    begin
      one = v[{4'h0, lsel} * 6'h09 +: 9];
      lo  = lsel[1] ? v[26:18] : v[8:0];
      hi  = lsel[1] ? v[35:27] : v[17:9];
      r   = 36'h000000000;
      case (wid)
        `WID_X1:  r[0]    = one[a];
        `WID_X2:  r[1:0]  = one[{a[1:0], 1'b0} +: 2];
        `WID_X4:  r[3:0]  = one[{a[0], 2'b00} +: 4];
        `WID_X8:  r[7:0]  = one[7:0];
        `WID_X9:  r[8:0]  = one;
        `WID_X16: r[15:0] = {hi[7:0], lo[7:0]};
        `WID_X18: r[17:0] = {hi, lo};
        `WID_X32: r[31:0] = {v[34:27], v[25:18], v[16:9], v[7:0]};
        `WID_X36: r       = v;
        default:  r       = 36'h000000000;
      endcase
      rdWord = r;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Configuration and Wishbone slave

  // CTRL holds shape, mode, read-during-write and ROM bits; INIT is a
  // write-only preload window into one lane; STAT holds the sticky
  // collision flag. Reads answer from the request edge, so wb_dat_o is
  // ready when ack is seen; writes land on the ack edge, so a request
  // dropped before ack changes nothing.
  reg  [7:0] ctrl_q;
  reg        collide_q;
  wire       collideEvt;

  wire [3:0] wid      = ctrl_q[`CTRL_WID_MSB:`CTRL_WID_LSB];
  wire [1:0] mode     = ctrl_q[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
  wire       rdwNew   = ctrl_q[`CTRL_RDW_NEW];
  wire       romMode  = ctrl_q[`CTRL_ROM];
  wire       isPacked = (mode == `MODE_PACKED);
  wire       portBOn  = (mode == `MODE_PACKED) || (mode == `MODE_DUAL);

  // Write lands on the edge where ack is seen high by the master
  wire       wbReq    = wb_cyc_i & wb_stb_i;
  wire       wbWrite  = wbReq & wb_we_i & wb_ack_o;
  wire       initWe   = wbWrite && (wb_adr_i == `REG_INIT) && (wb_sel_i == 4'hf);
  wire [9:0] initLane = wb_dat_i[`INIT_LANE_MSB:`INIT_LANE_LSB];
  wire [8:0] initData = wb_dat_i[`INIT_DATA_MSB:`INIT_DATA_LSB];

  // Ack one cycle after the request, dropped the cycle after
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wbReq & ~wb_ack_o;
      if (wbReq & ~wb_ack_o) begin
        case (wb_adr_i)
          `REG_CTRL: wb_dat_o <= {24'h000000, ctrl_q};
          `REG_STAT: wb_dat_o <= {31'h00000000, collide_q};
          default:   wb_dat_o <= 32'h00000000; // Unmapped and write-only read 0
        endcase
      end
    end
  end

  // Control register and sticky collision flag; a new event beats W1C
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_q    <= `CTRL_RESET;
      collide_q <= 1'b0;
    end else begin
      if (wbWrite && (wb_adr_i == `REG_CTRL) && wb_sel_i[0]) begin
        ctrl_q <= wb_dat_i[7:0];
      end
      if (collideEvt) begin
        collide_q <= 1'b1;
      end else if (wbWrite && (wb_adr_i == `REG_STAT) && wb_sel_i[0]
                   && wb_dat_i[`STAT_COLLIDE]) begin
        collide_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Port qualification

  // Each port is sampled on every edge it is enabled. clkEnIn alone
  // gates writes; a read needs both enables, since the output register
  // sits behind clkEnOut. Single-port mode switches port B off fully,
  // and ROM use blocks user writes while the preload path stays open.
  // Input enable gates strobes; output enable gates the data register
  wire       wrA  = clkEnInA & writeEnA & ~romMode;
  wire       rdA  = clkEnInA & clkEnOutA & readEnA;
  wire       wrB  = portBOn & clkEnInB & writeEnB & ~romMode;
  wire       rdB  = portBOn & clkEnInB & clkEnOutB & readEnB;

  // One address per port serves both its read and its write
  wire [9:0] laneA = laneOf(wid, addrA, isPacked, 1'b0);
  wire [9:0] laneB = laneOf(wid, addrB, isPacked, 1'b1);
  wire [7:0] rowA  = laneA[9:2];
  wire [7:0] rowB  = laneB[9:2];
  wire [1:0] span  = spanOf(wid);
  wire       byteWide = (wid >= `WID_X8);

  wire [35:0] viewA;
  wire [35:0] viewB;
  wire [3:0]  weAv;
  wire [3:0]  weBv;

  ////////////////////////////////////////////////////////////////////////
  // Four 256 x 9 banks; 1024 lanes of 9 bits hold all 9216 bits

  // Both ports may write one bank in a cycle. Port B's assignment sits
  // last, so it owns a shared lane; the collision flag lets software see
  // that this happened. Preload sits after both and so beats them.
  genvar b;
  generate
    for (b = 0; b < `RAM_BANKS; b = b + 1) begin : bank
      reg  [8:0]  mem [0:`RAM_ROWS-1];
      // Bank number cut to two bits for the lane compares
      wire [31:0] bankNum  = b;
      wire [1:0]  bk       = bankNum[1:0];
      // A word spans all four banks, one bank pair, or a single bank
      wire        spanAll  = (span == 2'h2);
      wire        spanPair = (span == 2'h1);
      wire        spanOne  = (span == 2'h0);
      wire        hitA     = spanAll | (spanPair & (bk[1] == laneA[1]))
                             | (spanOne & (bk == laneA[1:0]));
      wire        hitB     = spanAll | (spanPair & (bk[1] == laneB[1]))
                             | (spanOne & (bk == laneB[1:0]));
      // Word lane carried by this bank; picks byte enable and data slice
      wire [1:0]  kIdx     = spanAll ? bk : (spanPair ? {1'b0, bk[0]} : 2'h0);
      wire [8:0] oldA = mem[rowA];
      wire [8:0] oldB = mem[rowB];
      // Narrow shapes write every time; byte shapes obey their enable
      wire       weA  = wrA & hitA & (~byteWide | byteEnA[kIdx]);
      wire       weB  = wrB & hitB & (~byteWide | byteEnB[kIdx]);
      wire [8:0] newA = wrLane(wid, oldA, dataInA, kIdx, addrA[2:0]);
      wire [8:0] newB = wrLane(wid, oldB, dataInB, kIdx, addrB[2:0]);

      // Own-port write shown on read only when new data is chosen.
      // The other port's same-cycle write is not forwarded: that would
      // need a cross-port bypass for a case software is warned about.
      assign viewA[9*b +: 9] = (rdwNew && weA) ? newA : oldA;
      assign viewB[9*b +: 9] = (rdwNew && weB) ? newB : oldB;
      assign weAv[b] = weA;
      assign weBv[b] = weB;

      // Up to three writers per cycle; on one lane port B lands after A, preload last
      always @(posedge clk_sys) begin
        if (weA) begin
          mem[rowA] <= newA;
        end
        if (weB) begin
          mem[rowB] <= newB;
        end
        if (initWe && initLane[1:0] == bk) begin
          mem[initLane[9:2]] <= initData; // Preload, also in ROM use
        end
      end
    end
  endgenerate

  // Same-row write from both ports flags a collision. Per-bank enables
  // are ANDed first, so two ports writing different lanes of one row
  // (narrow shapes, other banks) do not count.
  assign collideEvt = |(weAv & weBv) && (rowA == rowB);

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs

  // Port A output only moves on an enabled read; writes alone leave it
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dataOutA <= 36'h000000000;
    end else begin
      if (rdA) begin
        dataOutA <= rdWord(wid, viewA, laneA[1:0], addrA[2:0]);
      end
    end
  end

  // Port B output likewise; frozen while single-port mode holds B off
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dataOutB <= 36'h000000000;
    end else begin
      if (rdB) begin
        dataOutB <= rdWord(wid, viewB, laneB[1:0], addrB[2:0]);
      end
    end
  end

endmodule
`default_nettype wire

// ---- embedded_ram_block_defs.vh ----
// Constants for the embedded RAM block: register map, fields, codes.
// Assumes inclusion by bare name from the RAM block design file.
`ifndef EMBEDDED_RAM_BLOCK_DEFS_VH
`define EMBEDDED_RAM_BLOCK_DEFS_VH

// Capacity
`define RAM_DATA_BITS    8192
`define RAM_TOTAL_BITS   9216
`define RAM_LANE_BITS    9
`define RAM_LANES        1024
`define RAM_ROWS         256
`define RAM_BANKS        4

// Wishbone register byte offsets
`define REG_CTRL         8'h00
`define REG_INIT         8'h04
`define REG_STAT         8'h08

// Control register fields and reset value
`define CTRL_WID_LSB     0
`define CTRL_WID_MSB     3
`define CTRL_MODE_LSB    4
`define CTRL_MODE_MSB    5
`define CTRL_RDW_NEW     6
`define CTRL_ROM         7
`define CTRL_RESET       8'h08

// Lane preload register fields
`define INIT_DATA_LSB    0
`define INIT_DATA_MSB    8
`define INIT_LANE_LSB    16
`define INIT_LANE_MSB    25

// Status register fields
`define STAT_COLLIDE     0

// Port modes
`define MODE_SINGLE      2'h0
`define MODE_PACKED      2'h1
`define MODE_DUAL        2'h2

// Width codes (depth x width)
`define WID_X1           4'h0
`define WID_X2           4'h1
`define WID_X4           4'h2
`define WID_X8           4'h3
`define WID_X9           4'h4
`define WID_X16          4'h5
`define WID_X18          4'h6
`define WID_X32          4'h7
`define WID_X36          4'h8

`endif

// ---- embedded_ram_block_assertions.sv ----
// Checker for the RAM block: bus handshake and port output hold.
// Assumes binding onto the RAM block top, ports matched by name.
`timescale 1ns/1ps
`default_nettype none
module embedded_ram_block_assertions (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic [7:0]  wb_adr_i,
  input wire logic        wb_we_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        readEnA,
  input wire logic        clkEnInA,
  input wire logic        clkEnOutA,
  input wire logic [35:0] dataOutA,
  input wire logic        readEnB,
  input wire logic        clkEnInB,
  input wire logic        clkEnOutB,
  input wire logic [35:0] dataOutB
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Fresh request: ack low means not yet answered
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  ack_resp_a: assert property (req |=> wb_ack_o) else $error("ack missing");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
  unmap_rd_a: assert property (req && !wb_we_i && wb_adr_i != 8'h00 && wb_adr_i != 8'h08
    |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  stat_rd_a: assert property (req && !wb_we_i && wb_adr_i == 8'h08
    |=> wb_dat_o[31:1] == 31'h0) else $error("status spare bits set");
  dat_keep_a: assert property (!req |=> $stable(wb_dat_o)) else $error("read data moved");
  hold_outa_a: assert property (!(readEnA && clkEnInA && clkEnOutA)
    |=> $stable(dataOutA)) else $error("port A output moved");
  hold_outb_a: assert property (!(readEnB && clkEnInB && clkEnOutB)
    |=> $stable(dataOutB)) else $error("port B output moved");
  // Main traffic kinds
  cover property (req && wb_we_i);
  cover property (readEnA && clkEnInA && clkEnOutA);
  cover property (readEnA && readEnB);
endmodule
`default_nettype wire

// ---- fabric_user.sv ----
// Fabric user logic for one RAM port, on the port clock.
// Assumes the bench calls acc from one thread per port.
`timescale 1ns/1ps
`default_nettype none
module fabric_user (
  input  wire logic        clk_sys,
  output var  logic [12:0] addr,
  output var  logic [35:0] dataIn,
  output var  logic [3:0]  byteEn,
  output var  logic        readEn,
  output var  logic        writeEn,
  output var  logic        clkEnIn,
  output var  logic        clkEnOut
);
  // Quiet port at time zero
  initial begin
    {addr, dataIn, byteEn, readEn, writeEn, clkEnIn, clkEnOut} = '0;
  end
  // One access held for one edge; released lines flip so stale data never looks valid
  task automatic acc(input logic [1:0] rw, input logic [12:0] a, input logic [35:0] d,
                     input logic [3:0] be, input logic [1:0] ce);
    @(posedge clk_sys);
    {readEn, writeEn} <= rw;
    addr <= a;
    dataIn <= d;
    byteEn <= be;
    {clkEnIn, clkEnOut} <= ce;
    @(posedge clk_sys);
    {readEn, writeEn} <= 2'h0;
    addr <= ~a;
    dataIn <= ~d;
    #1;
  endtask
endmodule
`default_nettype wire

// ---- embedded_ram_block_tb_top.sv ----
// Self-checking bench for the RAM block: bus setup, port traffic.
// Assumes the block, its defines header, checker and user model.
`timescale 1ns/1ps
`default_nettype none
`include "embedded_ram_block_defs.vh"
module embedded_ram_block_tb_top;
  logic        clk_sys = 1'b0, rstn = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0]  wb_sel_i = 4'hf;
  logic        wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o, readEnA, readEnB, writeEnA, writeEnB;
  wire         clkEnInA, clkEnInB, clkEnOutA, clkEnOutB;
  wire  [12:0] addrA, addrB;
  wire  [35:0] dataInA, dataInB, dataOutA, dataOutB;
  wire  [3:0]  byteEnA, byteEnB;
  int          fails = 0, numChecks = 0, cycles = 0;
  embedded_ram_block u_dut (.*);
  fabric_user pa (.clk_sys(clk_sys), .addr(addrA), .dataIn(dataInA), .byteEn(byteEnA),
    .readEn(readEnA), .writeEn(writeEnA), .clkEnIn(clkEnInA), .clkEnOut(clkEnOutA));
  fabric_user pb (.clk_sys(clk_sys), .addr(addrB), .dataIn(dataInB), .byteEn(byteEnB),
    .readEn(readEnB), .writeEn(writeEnB), .clkEnIn(clkEnInB), .clkEnOut(clkEnOutB));
  always #10 clk_sys = ~clk_sys;
  // Run takes about 100 cycles; a hang is cut well past that
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 1000) begin
      fails++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", numChecks, fails);
    if (fails == 0 && numChecks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    numChecks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Classic single cycle, held until ack is sampled high
  task automatic wbx(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk_sys);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, we};
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask
  task automatic wbw(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wbx(1'b1, a, d, q);
  endtask
  task automatic wbr(input logic [7:0] a, input logic [35:0] e);
    logic [31:0] q;
    wbx(1'b0, a, 32'h0, q);
    chk({4'h0, q}, e);
  endtask
  task automatic ra(input logic [12:0] a, input logic [35:0] e);
    pa.acc(2'h2, a, 36'h0, 4'hf, 2'h3);
    chk(dataOutA, e);
  endtask
  task automatic rb(input logic [12:0] a, input logic [35:0] e);
    pb.acc(2'h2, a, 36'h0, 4'hf, 2'h3);
    chk(dataOutB, e);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    wbr(`REG_CTRL, 36'h8);
    wbr(`REG_STAT, 36'h0);
    wbr(8'h0c, 36'h0);
    wbr(`REG_INIT, 36'h0);
    pa.acc(2'h1, 13'h5, 36'h912345678, 4'hf, 2'h3);
    ra(13'h5, 36'h912345678);
    pa.acc(2'h1, 13'h5, 36'h0, 4'h5, 2'h3);
    ra(13'h5, 36'h910005600);
    pa.acc(2'h3, 13'h5, 36'h0aaaaaaaa, 4'hf, 2'h3);
    chk(dataOutA, 36'h910005600);
    wbw(`REG_CTRL, 32'h48);
    pa.acc(2'h3, 13'h5, 36'h155555555, 4'hf, 2'h3);
    chk(dataOutA, 36'h155555555);
    pa.acc(2'h1, 13'h6, 36'h0, 4'hf, 2'h3);
    chk(dataOutA, 36'h155555555);
    pa.acc(2'h1, 13'h5, 36'h0, 4'hf, 2'h1);
    pa.acc(2'h2, 13'h6, 36'h0, 4'hf, 2'h2);
    chk(dataOutA, 36'h155555555);
    ra(13'h5, 36'h155555555);
    wbw(`REG_CTRL, 32'h43);
    ra(13'h14, 36'h55);
    wbw(`REG_CTRL, 32'h40);
    ra(13'ha2, 36'h1);
    wbw(`REG_CTRL, 32'h45);
    ra(13'ha, 36'haa55);
    // True dual: two writes, then two reads crossed over
    wbw(`REG_CTRL, 32'h28);
    fork
      pa.acc(2'h1, 13'h9, 36'h876543210, 4'hf, 2'h3);
      pb.acc(2'h1, 13'ha, 36'habcdef012, 4'hf, 2'h3);
    join
    fork
      ra(13'ha, 36'habcdef012);
      rb(13'h9, 36'h876543210);
    join
    fork
      pa.acc(2'h1, 13'hb, 36'h1, 4'hf, 2'h3);
      pb.acc(2'h1, 13'hb, 36'h2, 4'hf, 2'h3);
    join
    wbr(`REG_STAT, 36'h1);
    wbw(`REG_STAT, 32'h1);
    wbr(`REG_STAT, 36'h0);
    wbw(`REG_CTRL, 32'h08);
    rb(13'ha, 36'h876543210);
    wbw(`REG_CTRL, 32'h18);
    fork
      pa.acc(2'h1, 13'h0, 36'h111111111, 4'hf, 2'h3);
      pb.acc(2'h1, 13'h0, 36'h222222222, 4'hf, 2'h3);
    join
    ra(13'h0, 36'h111111111);
    rb(13'h0, 36'h222222222);
    // Preload one lane with user writes blocked
    wbw(`REG_CTRL, 32'h88);
    wbw(`REG_INIT, 32'h002401a5);
    pa.acc(2'h1, 13'h9, 36'h0, 4'hf, 2'h3);
    ra(13'h9, 36'h8765433a5);
    give_verdict();
  end
endmodule
bind embedded_ram_block embedded_ram_block_assertions u_chk (.*);
`default_nettype wire
